// *** hw/seq_defines.svh ***
// constants for the endian, reservation and program counter sequencer
//
// Behaviour
// - byte-order pin is captured once after reset: 0 little, 1 big
// - captured order drives memory interface and kernel/supervisor execution
// - user flip is high only when control flip bit set and in user mode
// - load/store order is captured order XOR user flip
// - linked load sets reservation flag; conditional store tests it
// - other activity breaking atomicity clears the reservation flag
// - exception return clears the reservation flag
// - program counter holds current instruction address during its time
// - unassigned counter advances by 2 after compressed with width select 1, else by 4
// - taken branch target loads during the delay slot's instruction time
// - program counter is a full 64-bit address, all bits significant
// - instruction effects land within that instruction's own time, except late result write and taken branch target load
// - late result write takes effect in the next instruction time
// - one instruction's effects keep order; none between instructions
// - program-counter-relative address computation and loads are supported
// - width select is 0 for 32-bit, 1 for compressed instruction sets
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CTRL_OFS       8'h00
`define STAT_OFS       8'h04
`define PC_LO_OFS      8'h08
`define PC_HI_OFS      8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_FLIP_BIT  0
`define CTRL_USER_BIT  1
`define CTRL_WIDTH_BIT 2
`define STAT_MEM_BIT   0
`define STAT_LS_BIT    1
`define STAT_FLIP_BIT  2
`define STAT_LL_BIT    3
`define STAT_RUN_BIT   4

// ----------------------------------------
// reset values and steps
// ----------------------------------------
`define CTRL_RESET     3'h0
`define PC_RESET       64'h0000_0000_0000_0000
`define STEP_WIDE      64'h0000_0000_0000_0004
`define STEP_NARROW    64'h0000_0000_0000_0002

`endif

// *** hw/seq_pkg.sv ***
// shared types of the sequencer
package seq_pkg;
  typedef logic [63:0] addr_t;
  typedef logic [4:0]  reg_idx_t;
  typedef enum logic {ST_STRAP, ST_RUN} run_state_t;
endpackage

// *** hw/pc_if.sv ***
// carrier between sequencer core and program counter unit
`timescale 1ns/100ps
interface pc_if;
  logic          advance;
  logic          narrow;
  logic          taken;
  seq_pkg::addr_t target;
  logic          redirect;
  seq_pkg::addr_t redirect_addr;
  seq_pkg::addr_t pc;
  logic          in_slot;
  seq_pkg::addr_t branch_pc;
  modport core (output advance, narrow, taken, target, redirect, redirect_addr,
                input pc, in_slot, branch_pc);
  modport unit (input advance, narrow, taken, target, redirect, redirect_addr,
                output pc, in_slot, branch_pc);
endinterface

// *** hw/pc_unit.sv ***
// program counter with automatic step and branch delay slot
`timescale 1ns/100ps
`include "seq_defines.svh"
module pc_unit (
  input  wire logic i_clock,
  input  wire logic i_reset,
  pc_if.unit        pcb
);
  seq_pkg::addr_t pc_r;
  seq_pkg::addr_t target_r;
  seq_pkg::addr_t branch_pc_r;
  logic           pending_r;
  logic           in_slot_r;
  seq_pkg::addr_t step;
  seq_pkg::addr_t pc_nxt;

  assign step   = pcb.narrow ? `STEP_NARROW : `STEP_WIDE;
  assign pc_nxt = pcb.redirect ? pcb.redirect_addr :
                  pending_r    ? target_r :
                  pc_r + step;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pc_r        <= `PC_RESET;
      target_r    <= `PC_RESET;
      branch_pc_r <= `PC_RESET;
      pending_r   <= 1'b0;
      in_slot_r   <= 1'b0;
    end else if (pcb.advance) begin
      pc_r      <= pc_nxt;
      pending_r <= pcb.taken & ~pcb.redirect;
      in_slot_r <= pcb.taken & ~pcb.redirect;
      if (pcb.taken) begin
        target_r    <= pcb.target;
        branch_pc_r <= pc_r;
      end
    end
  end

  assign pcb.pc        = pc_r;
  assign pcb.in_slot   = in_slot_r;
  assign pcb.branch_pc = branch_pc_r;
endmodule // pc_unit

// *** hw/reservation_unit.sv ***
// atomic reservation flag and conditional store verdict
`timescale 1ns/100ps
module reservation_unit (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_step,
  input  wire logic i_linked_load,
  input  wire logic i_cond_store,
  input  wire logic i_break_atomic,
  input  wire logic i_exc_return,
  output logic      o_flag,
  output logic      o_store_en,
  output logic      o_sc_done,
  output logic      o_sc_ok
);
  logic flag_r;
  logic flag_nxt;
  logic done_r;
  logic ok_r;
  logic set_ev;
  logic clr_ev;

  assign set_ev = i_step & i_linked_load;
  // a set in the same cycle as a clear wins, so a fresh reservation survives
  assign clr_ev = i_break_atomic | (i_step & i_exc_return);
  assign flag_nxt = set_ev | (flag_r & ~clr_ev);
  assign o_store_en = i_step & i_cond_store & flag_r;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flag_r <= 1'b0;
      done_r <= 1'b0;
      ok_r   <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      done_r <= i_step & i_cond_store;
      ok_r   <= i_step & i_cond_store & flag_r;
    end
  end

  assign o_flag    = flag_r;
  assign o_sc_done = done_r;
  assign o_sc_ok   = ok_r;
endmodule // reservation_unit

// *** hw/endian_link_pc_sequencer.sv ***
// sequencer core: byte order, reservation, program counter, result writes
`timescale 1ns/100ps
`include "seq_defines.svh"
module endian_link_pc_sequencer (
  input  wire logic            i_clock,
  input  wire logic            i_reset,
  input  wire logic            i_memory_order_pin,
  input  wire logic [7:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [31:0]     o_rdata,
  output logic                 o_ready,
  input  wire logic            i_instr_valid,
  input  wire logic            i_compressed,
  input  wire logic            i_branch_taken,
  input  wire logic [63:0]     i_branch_target,
  input  wire logic            i_link,
  input  wire logic [4:0]      i_link_reg,
  input  wire logic            i_pcrel,
  input  wire logic [63:0]     i_pcrel_offset,
  input  wire logic            i_linked_load,
  input  wire logic            i_cond_store,
  input  wire logic            i_break_atomic,
  input  wire logic            i_exception,
  input  wire logic [63:0]     i_exc_vector,
  input  wire logic            i_exc_return,
  input  wire logic [63:0]     i_return_addr,
  input  wire logic            i_late_wr,
  input  wire logic [4:0]      i_late_reg,
  input  wire logic [63:0]     i_late_data,
  output logic      [63:0]     o_pc,
  output logic                 o_memory_order_at_reset,
  output logic                 o_load_store_byte_order,
  output logic                 o_user_byte_order_flip,
  output logic                 o_atomic_reservation_flag,
  output logic                 o_instruction_width_select,
  output logic                 o_sc_store_en,
  output logic                 o_sc_done,
  output logic                 o_sc_ok,
  output logic      [63:0]     o_pcrel_addr,
  output logic                 o_link_wr,
  output logic      [4:0]      o_link_reg,
  output logic      [63:0]     o_link_data,
  output logic                 o_restart_wr,
  output logic      [63:0]     o_restart_data,
  output logic                 o_late_wr,
  output logic      [4:0]      o_late_reg,
  output logic      [63:0]     o_late_data
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pc_if                 pcb ();
  seq_pkg::run_state_t  state_r;
  seq_pkg::run_state_t  state_nxt;
  logic                 pin_meta_r;
  logic                 pin_sync_r;
  logic                 mem_order_r;
  logic [2:0]           ctrl_r;
  logic                 flip_r;
  logic                 ls_order_r;
  logic                 width_r;
  logic                 step;
  logic                 user_flip;
  logic                 ls_order;
  logic                 res_flag;
  logic                 hit_ctrl;
  logic                 hit_stat;
  logic                 hit_pc_lo;
  logic                 hit_pc_hi;
  logic [31:0]          stat_word;
  logic [31:0]          rd_word;
  logic [31:0]          rdata_r;
  seq_pkg::addr_t       pcrel_r;
  seq_pkg::addr_t       link_addr;
  seq_pkg::addr_t       restart_addr;
  logic                 link_wr_r;
  seq_pkg::reg_idx_t    link_reg_r;
  seq_pkg::addr_t       link_data_r;
  logic                 restart_wr_r;
  seq_pkg::addr_t       restart_r;
  logic                 late_hold_r;
  seq_pkg::reg_idx_t    late_hold_reg_r;
  seq_pkg::addr_t       late_hold_data_r;
  logic                 late_wr_r;
  seq_pkg::reg_idx_t    late_reg_r;
  seq_pkg::addr_t       late_data_r;

  // ----------------------------------------
  // byte-order strap
  // ----------------------------------------
  // pin is asynchronous; only the second stage is read
  // no reset on the sync pair: it keeps sampling through reset,
  // so the strap value is already settled when reset lets go
  always_ff @(posedge i_clock) begin
    pin_meta_r <= i_memory_order_pin;
    pin_sync_r <= pin_meta_r;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      seq_pkg::ST_STRAP: begin
        state_nxt = seq_pkg::ST_RUN;
      end
      seq_pkg::ST_RUN: begin
        state_nxt = seq_pkg::ST_RUN;
      end
      default: begin
        state_nxt = seq_pkg::ST_STRAP;
      end
    endcase
  end

  // strap taken once after release; later pin moves are ignored
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r     <= seq_pkg::ST_STRAP;
      mem_order_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == seq_pkg::ST_STRAP) begin
        mem_order_r <= pin_sync_r;
      end
    end
  end

  // ----------------------------------------
  // instruction stepping
  // ----------------------------------------
  // strap is captured in the one strap-state cycle, so stepping waits for run state
  assign o_ready = (state_r == seq_pkg::ST_RUN);
  assign step = i_instr_valid & o_ready;

  // ----------------------------------------
  // byte order
  // ----------------------------------------
  assign user_flip = ctrl_r[`CTRL_FLIP_BIT] & ctrl_r[`CTRL_USER_BIT];
  assign ls_order  = mem_order_r ^ user_flip;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flip_r     <= 1'b0;
      ls_order_r <= 1'b0;
      width_r    <= 1'b0;
    end else begin
      flip_r     <= user_flip;
      ls_order_r <= ls_order;
      width_r    <= ctrl_r[`CTRL_WIDTH_BIT];
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  assign pcb.advance       = step;
  // step size follows the visible width select, so both agree every cycle
  assign pcb.narrow        = i_compressed & width_r;
  assign pcb.taken         = i_branch_taken;
  assign pcb.target        = i_branch_target;
  assign pcb.redirect      = i_exception | i_exc_return;
  assign pcb.redirect_addr = i_exception ? i_exc_vector : i_return_addr;

  pc_unit u_pc (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .pcb     (pcb)
  );

  // ----------------------------------------
  // reservation
  // ----------------------------------------
  reservation_unit u_res (
    .i_clock        (i_clock),
    .i_reset        (i_reset),
    .i_step         (step),
    .i_linked_load  (i_linked_load),
    .i_cond_store   (i_cond_store),
    .i_break_atomic (i_break_atomic),
    .i_exc_return   (i_exc_return),
    .o_flag         (res_flag),
    .o_store_en     (o_sc_store_en),
    .o_sc_done      (o_sc_done),
    .o_sc_ok        (o_sc_ok)
  );

  // ----------------------------------------
  // link, restart and relative addresses
  // ----------------------------------------
  // link address skips the delay slot; low bit carries the width select
  assign link_addr = {pcb.pc[63:1] + (pcb.narrow ? 63'h0000_0000_0000_0002
                                                 : 63'h0000_0000_0000_0004),
                      width_r};
  // an exception in a delay slot restarts at the branch
  assign restart_addr = pcb.in_slot ? pcb.branch_pc : pcb.pc;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      link_wr_r    <= 1'b0;
      link_reg_r   <= 5'h00;
      link_data_r  <= `PC_RESET;
      restart_wr_r <= 1'b0;
      restart_r    <= `PC_RESET;
      pcrel_r      <= `PC_RESET;
    end else begin
      link_wr_r    <= step & i_link & ~i_exception;
      restart_wr_r <= step & i_exception;
      if (step & i_link) begin
        link_reg_r  <= i_link_reg;
        link_data_r <= link_addr;
      end
      if (step & i_exception) begin
        restart_r <= restart_addr;
      end
      if (step & i_pcrel) begin
        pcrel_r <= pcb.pc + i_pcrel_offset;
      end
    end
  end

  // ----------------------------------------
  // late result write
  // ----------------------------------------
  // held result lands at the next instruction time, unordered vs its effects
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      late_hold_r      <= 1'b0;
      late_hold_reg_r  <= 5'h00;
      late_hold_data_r <= `PC_RESET;
      late_wr_r        <= 1'b0;
      late_reg_r       <= 5'h00;
      late_data_r      <= `PC_RESET;
    end else begin
      late_wr_r <= step & late_hold_r;
      if (step) begin
        late_reg_r       <= late_hold_reg_r;
        late_data_r      <= late_hold_data_r;
        late_hold_r      <= i_late_wr;
        late_hold_reg_r  <= i_late_reg;
        late_hold_data_r <= i_late_data;
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  assign hit_ctrl  = (i_addr == `CTRL_OFS);
  assign hit_stat  = (i_addr == `STAT_OFS);
  assign hit_pc_lo = (i_addr == `PC_LO_OFS);
  assign hit_pc_hi = (i_addr == `PC_HI_OFS);

  assign stat_word = {27'h000_0000,
                      state_r == seq_pkg::ST_RUN,
                      res_flag,
                      user_flip,
                      ls_order,
                      mem_order_r};

  // unmapped offsets read as zero
  assign rd_word = hit_ctrl  ? {29'h0000_0000, ctrl_r} :
                   hit_stat  ? stat_word :
                   hit_pc_lo ? pcb.pc[31:0] :
                   hit_pc_hi ? pcb.pc[63:32] :
                   32'h0000_0000;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_r  <= `CTRL_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (i_wr & hit_ctrl) begin
        ctrl_r <= i_wdata[2:0];
      end
      rdata_r <= i_rd ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata                    = rdata_r;
  assign o_pc                       = pcb.pc;
  assign o_memory_order_at_reset    = mem_order_r;
  assign o_load_store_byte_order    = ls_order_r;
  assign o_user_byte_order_flip     = flip_r;
  assign o_atomic_reservation_flag  = res_flag;
  assign o_instruction_width_select = width_r;
  assign o_pcrel_addr               = pcrel_r;
  assign o_link_wr                  = link_wr_r;
  assign o_link_reg                 = link_reg_r;
  assign o_link_data                = link_data_r;
  assign o_restart_wr               = restart_wr_r;
  assign o_restart_data             = restart_r;
  assign o_late_wr                  = late_wr_r;
  assign o_late_reg                 = late_reg_r;
  assign o_late_data                = late_data_r;
endmodule // endian_link_pc_sequencer

// *** sim/mem_model.sv ***
// store target model: counts conditional stores that reach memory
`timescale 1ns/100ps
module mem_model (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_store_en,
  output logic      [7:0] o_writes
);
  // counts only, data is not kept
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_writes <= 8'h0;
    end else if (i_store_en) begin
      o_writes <= o_writes + 8'h1;
    end
  end
endmodule // mem_model

// *** sim/seq_asserts.sv ***
// concurrent checks on the sequencer top ports
`timescale 1ns/100ps
module seq_asserts (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_instr_valid,
  input wire logic        i_compressed,
  input wire logic        i_branch_taken,
  input wire logic [63:0] i_branch_target,
  input wire logic        i_link,
  input wire logic        i_linked_load,
  input wire logic        i_cond_store,
  input wire logic        i_break_atomic,
  input wire logic        i_exception,
  input wire logic [63:0] i_exc_vector,
  input wire logic        i_exc_return,
  input wire logic [63:0] i_return_addr,
  input wire logic        o_ready,
  input wire logic [63:0] o_pc,
  input wire logic        o_memory_order_at_reset,
  input wire logic        o_load_store_byte_order,
  input wire logic        o_user_byte_order_flip,
  input wire logic        o_atomic_reservation_flag,
  input wire logic        o_instruction_width_select,
  input wire logic        o_sc_store_en,
  input wire logic        o_sc_done,
  input wire logic        o_sc_ok,
  input wire logic        o_link_wr,
  input wire logic [63:0] o_link_data,
  input wire logic        o_restart_wr
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic        pend_r;
  logic        pend_nxt;
  logic [63:0] tgt_r;
  logic [63:0] tgt_nxt;
  logic [63:0] step_sz;
  logic [63:0] link_sum;
  wire         step = i_instr_valid & o_ready;
  // exception or return cancels a branch waiting on its slot
  assign pend_nxt = step ? (i_branch_taken & ~i_exception & ~i_exc_return) : pend_r;
  assign tgt_nxt  = (step & i_branch_taken) ? i_branch_target : tgt_r;
  assign step_sz  = (o_instruction_width_select & i_compressed) ? {60'h0, 4'h2} : {60'h0, 4'h4};
  assign link_sum = o_pc + {step_sz[62:0], 1'b0};
  always_ff @(posedge i_clock) begin
    pend_r <= i_reset ? 1'h0 : pend_nxt;
    tgt_r  <= tgt_nxt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_LS_ORDER: assert property (o_ready && $stable(o_memory_order_at_reset) |->
    o_load_store_byte_order == (o_memory_order_at_reset ^ o_user_byte_order_flip))
    else $error("load/store order not captured order xor flip");
  AST_LL_SET: assert property (step && i_linked_load |=> o_atomic_reservation_flag)
    else $error("linked load left flag clear");
  AST_BREAK: assert property (i_break_atomic && !(step && i_linked_load) |=>
    !o_atomic_reservation_flag) else $error("flag survived atomic break");
  AST_ERET: assert property (step && i_exc_return && !i_linked_load && !i_exception |=>
    !o_atomic_reservation_flag && o_pc == $past(i_return_addr)) else $error("return wrong");
  AST_SC_EN: assert property (o_sc_store_en ==
    (step && i_cond_store && o_atomic_reservation_flag)) else $error("store enable wrong");
  AST_SC_RES: assert property (step && i_cond_store |=> o_sc_done &&
    o_sc_ok == $past(o_atomic_reservation_flag)) else $error("store verdict wrong");
  AST_PC_STEP: assert property (step && !pend_r && !i_exception && !i_exc_return |=>
    o_pc == $past(o_pc) + $past(step_sz)) else $error("pc step wrong");
  AST_BRANCH: assert property (step && pend_r && !i_exception && !i_exc_return |=>
    o_pc == $past(tgt_r)) else $error("branch target not loaded after slot");
  AST_LINK: assert property (step && i_link |=> o_link_wr &&
    o_link_data == {$past(link_sum[63:1]), $past(o_instruction_width_select)})
    else $error("link write wrong");
  AST_EXC: assert property (step && i_exception |=> o_restart_wr &&
    o_pc == $past(i_exc_vector)) else $error("exception redirect wrong");
  COV_SLOT: cover property (step && pend_r);
  COV_SC_FAIL: cover property (o_sc_done && !o_sc_ok);
  COV_EXC: cover property (o_restart_wr);
endmodule // seq_asserts

// *** sim/endian_link_pc_sequencer_tb.sv ***
// self-checking bench for the sequencer
`timescale 1ns/100ps
module endian_link_pc_sequencer_tb;
  typedef struct packed {logic [2:0] ctrl; logic cmp; logic [2:0] dpc; logic flip;} row_t;
  localparam logic [8:0] TKN = 9'h080, LNK = 9'h040, REL = 9'h020, LL = 9'h010;
  localparam logic [8:0] SC = 9'h008, EXC = 9'h004, RET = 9'h002, LATE = 9'h001;
  localparam logic [63:0] TGT = 64'hFEDC_BA98_7654_3210;
  logic i_clock, i_reset, i_memory_order_pin, i_wr, i_rd, i_instr_valid, i_break_atomic;
  logic i_compressed, i_branch_taken, i_link, i_pcrel, i_linked_load, i_cond_store;
  logic i_exception, i_exc_return, i_late_wr, o_ready, o_memory_order_at_reset;
  logic o_load_store_byte_order, o_user_byte_order_flip, o_atomic_reservation_flag;
  logic o_instruction_width_select, o_sc_store_en, o_sc_done, o_sc_ok;
  logic o_link_wr, o_restart_wr, o_late_wr;
  logic [7:0]  i_addr, writes;
  logic [8:0]  flg;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [4:0]  i_link_reg, i_late_reg, o_link_reg, o_late_reg;
  logic [63:0] i_branch_target, i_pcrel_offset, i_exc_vector, i_return_addr, i_late_data;
  logic [63:0] o_pc, o_pcrel_addr, o_link_data, o_restart_data, o_late_data, p;
  int          fails = 0;
  int          n_compared = 0;
  // every ctrl combination; compressed only counts with width select set
  row_t rows [8] = '{'{3'h0, 1'h1, 3'h4, 1'h0}, '{3'h1, 1'h0, 3'h4, 1'h0},
    '{3'h2, 1'h0, 3'h4, 1'h0}, '{3'h3, 1'h0, 3'h4, 1'h1}, '{3'h4, 1'h1, 3'h2, 1'h0},
    '{3'h5, 1'h0, 3'h4, 1'h0}, '{3'h6, 1'h1, 3'h2, 1'h0}, '{3'h7, 1'h1, 3'h2, 1'h1}};
  assign {i_compressed, i_branch_taken, i_link, i_pcrel, i_linked_load, i_cond_store,
          i_exception, i_exc_return, i_late_wr} = flg;
  endian_link_pc_sequencer i_dut (.*);
  mem_model i_mem (.i_clock(i_clock), .i_reset(i_reset), .i_store_en(o_sc_store_en),
                   .o_writes(writes));
  always #12.5 i_clock = ~i_clock;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task automatic op(input logic [8:0] f);
    @(posedge i_clock);
    flg <= f;
    i_instr_valid <= 1'h1;
    @(posedge i_clock);
    flg <= 9'h0;
    i_instr_valid <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 rv = o_rdata;
  endtask
  task automatic rst(input logic pin);
    @(posedge i_clock);
    i_memory_order_pin <= pin;
    i_reset <= 1'h1;
    repeat (6) @(posedge i_clock);
    i_reset <= 1'h0;
    #1 chk(o_pc, 64'h0);
    @(posedge i_clock);
    #1 chk(o_memory_order_at_reset, pin);
    chk(o_ready, 1'h1);
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {i_clock, i_memory_order_pin, i_wr, i_rd, i_instr_valid, i_break_atomic, flg} = '0;
    i_reset = 1'h1;
    {i_addr, i_wdata, i_link_reg, i_branch_target, i_pcrel_offset} = '0;
    i_late_reg = 5'h09;
    i_late_data = 64'h0123_4567_89AB_CDEF;
    i_exc_vector = 64'h0000_0000_0000_0180;
    i_return_addr = 64'h0000_0000_0000_2000;
    rst(1'h0);
    rst(1'h1);
    foreach (rows[k]) begin
      wr(8'h00, {29'h0, rows[k].ctrl});
      p = o_pc;
      op({rows[k].cmp, 8'h0});
      chk(o_pc, p + rows[k].dpc);
      chk(o_user_byte_order_flip, rows[k].flip);
      chk(o_load_store_byte_order, !rows[k].flip);
      chk(o_instruction_width_select, rows[k].ctrl[2]);
      rd(8'h04);
      chk(rv[2:0], {rows[k].flip, !rows[k].flip, 1'h1});
    end
    rd(8'h10);
    chk(rv, 32'h0);
    wr(8'h00, 32'h0);
    p = o_pc;
    @(posedge i_clock);
    i_branch_target <= TGT;
    i_pcrel_offset <= 64'h0000_0000_0000_0100;
    i_link_reg <= 5'h1F;
    flg <= TKN | LNK;
    i_instr_valid <= 1'h1;
    @(posedge i_clock);
    flg <= 9'h0;
    #1 chk(o_pc, p + 64'h4);
    chk({o_link_wr, o_link_reg}, 6'h3F);
    chk(o_link_data, p + 64'h8);
    @(posedge i_clock);
    i_instr_valid <= 1'h0;
    #1 chk(o_pc, TGT);
    op(REL);
    chk(o_pcrel_addr, 64'hFEDC_BA98_7654_3310);
    chk(o_pc, 64'hFEDC_BA98_7654_3214);
    op(LL);
    chk(o_atomic_reservation_flag, 1'h1);
    op(SC);
    chk({o_sc_done, o_sc_ok}, 2'h3);
    op(SC);
    chk(writes, 8'h2);
    @(posedge i_clock);
    i_break_atomic <= 1'h1;
    @(posedge i_clock);
    i_break_atomic <= 1'h0;
    #1 chk(o_atomic_reservation_flag, 1'h0);
    op(SC);
    chk({o_sc_done, o_sc_ok, writes}, 10'h202);
    op(LL);
    op(RET);
    chk(o_atomic_reservation_flag, 1'h0);
    chk(o_pc, i_return_addr);
    op(EXC);
    chk(o_restart_wr, 1'h1);
    chk(o_pc, i_exc_vector);
    chk(o_restart_data, i_return_addr);
    op(LATE);
    chk(o_late_wr, 1'h0);
    op(9'h0);
    chk({o_late_wr, o_late_reg}, 6'h29);
    chk(o_late_data, 64'h0123_4567_89AB_CDEF);
    stop_test;
  end
  // run needs under 100 cycles; allow 1000
  initial begin
    #25000;
    fails++;
    stop_test;
  end
endmodule // endian_link_pc_sequencer_tb
bind endian_link_pc_sequencer seq_asserts i_chk (.*);
